/* design/avfr_cfg.svh */
/*
  register map, field positions, reset values and fixed scales of the
  analog voltage frequency reference block.
  assumes: included by bare name from the top module.
*/
`ifndef AVFR_CFG_SVH
`define AVFR_CFG_SVH
// word index of each register, byte address is index times four
`define AVFR_IDX_CTRL 3'h0
`define AVFR_IDX_FMAX 3'h1
`define AVFR_IDX_FILT 3'h2
`define AVFR_IDX_QLVL 3'h3
`define AVFR_IDX_NMIN 3'h4
`define AVFR_IDX_NMAX 3'h5
`define AVFR_IDX_STAT 3'h6
// control word fields
`define AVFR_SRC_MSB 3
`define AVFR_BIP_BIT 4
`define AVFR_DIR_BIT 5
// reset values
`define AVFR_RST_SRC 4'h2
`define AVFR_RST_FMAX 16'h1770
`define AVFR_RST_FILT 4'h4
`define AVFR_RST_QLVL 16'h0004
`define AVFR_RST_NMIN_V 16'h0000
`define AVFR_RST_NMIN_P 16'h0000
`define AVFR_RST_NMAX_V 16'hd8f0
`define AVFR_RST_NMAX_P 16'hd8f0
// source code that selects the voltage input
`define AVFR_SRC_VIN 4'h2
// 10.000 V in mV, and 100.00 % in 0.01 % units
`define AVFR_FULL_SCALE 16'h2710
// fraction bits kept by the low-pass accumulator
`define AVFR_FRAC 8
`endif

/* design/avfr_pkg.sv */
/*
  types of the analog voltage frequency reference block.
  assumes: avfr_cfg.svh is on the include path.
*/
package avfr_pkg;
  // pipeline states, gray order along the path
  typedef enum logic [1:0] {
    AVFR_IDLE  = 2'b00,
    AVFR_FILT  = 2'b01,
    AVFR_SCALE = 2'b11,
    AVFR_OUT   = 2'b10
  } avfr_state_e;

  // software settings, travel together
  typedef struct packed {
    logic [3:0] src;
    logic bip;
    logic dir;
    logic [3:0] filt_k;
    logic [15:0] qlvl;
    logic [15:0] fmax;
    logic signed [15:0] nmin_v;
    logic signed [15:0] nmin_p;
    logic signed [15:0] nmax_v;
    logic signed [15:0] nmax_p;
  } avfr_cfg_s;
endpackage

/* design/avfr_top.sv */
/*
  analog voltage input to frequency reference: low-pass filter, polarity
  and negative-side scaling, hysteretic quantizer, frequency output, with
  a classic wishbone register slave.
  assumes: samples arrive in signed mV synchronous to CLK; one clock.
*/
// The Wishbone interface to the registers and the address map were chosen for this implementation.
// Functional notes
// R1 - quantizing level is percent of maximum input
// R2 - rising: change after three quarter step
// R3 - falling: change after one quarter step
// R4 - configurable low-pass filter on voltage input
// R5 - source selector two picks voltage input
// R6 - polarity option one allows bipolar input
// R7 - negative range scales between programmable endpoints
// R8 - programmable full-scale frequency, default 60 Hz
// R9 - zero quantizing level bypasses the quantizer
// R10 - negative voltage reverses commanded direction
// R11 - interpolate linearly, clamp at endpoints
`timescale 1ns/100ps
`default_nettype none
`include "avfr_cfg.svh"
module avfr_top #(
  parameter int SMP_W = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [4:2] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // digitised voltage input, signed mV
  input wire logic signed [SMP_W-1:0] AIN_MV,
  input wire logic AIN_VALID,
  // frequency reference, 0.01 Hz units, and direction
  output logic [15:0] FREQ_HZ,
  output logic REV,
  output logic ACTIVE
);
  avfr_pkg::avfr_cfg_s cfg; // software settings
  avfr_pkg::avfr_state_e st; // pipeline state
  logic signed [23:0] acc; // filter accumulator, mV with fraction
  logic signed [16:0] pct; // scaled reference, 0.01 %
  logic [16:0] lvl; // quantized magnitude
  logic neg; // sign of held level
  logic [31:0] rd_word; // read mux
  logic signed [15:0] v; // filtered voltage
  logic signed [16:0] next_pct;
  logic [16:0] next_lvl;
  logic [16:0] mag; // magnitude of pct
  logic [16:0] qd; // divisor, never zero
  logic [16:0] up; // target when rising
  logic [16:0] dn; // target when falling
  logic signed [24:0] diff; // filter error
  logic signed [33:0] num; // interpolation numerator
  logic signed [16:0] den; // interpolation span
  logic [32:0] prod; // level times full-scale frequency
  logic wr; // write takes effect this edge

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    end
  end

  // write lands on the edge where the master sees ack
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;

  // read mux, unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (WB_ADR_I)
      `AVFR_IDX_CTRL: rd_word = {26'h0, cfg.dir, cfg.bip, cfg.src};
      `AVFR_IDX_FMAX: rd_word = {16'h0, cfg.fmax};
      `AVFR_IDX_FILT: rd_word = {v, 12'h0, cfg.filt_k};
      `AVFR_IDX_QLVL: rd_word = {16'h0, cfg.qlvl};
      `AVFR_IDX_NMIN: rd_word = {cfg.nmin_p, cfg.nmin_v};
      `AVFR_IDX_NMAX: rd_word = {cfg.nmax_p, cfg.nmax_v};
      `AVFR_IDX_STAT: rd_word = {14'h0, ACTIVE, REV, FREQ_HZ};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read data registered with the ack
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
      WB_DAT_O <= rd_word;
    end
  end

  // settings registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg.src <= `AVFR_RST_SRC;
      cfg.bip <= 1'b0;
      cfg.dir <= 1'b0;
      cfg.filt_k <= `AVFR_RST_FILT;
      cfg.qlvl <= `AVFR_RST_QLVL;
      cfg.fmax <= `AVFR_RST_FMAX;
      cfg.nmin_v <= `AVFR_RST_NMIN_V;
      cfg.nmin_p <= `AVFR_RST_NMIN_P;
      cfg.nmax_v <= `AVFR_RST_NMAX_V;
      cfg.nmax_p <= `AVFR_RST_NMAX_P;
    end else if (wr) begin
      case (WB_ADR_I)
        `AVFR_IDX_CTRL: begin
          {cfg.dir, cfg.bip, cfg.src} <= 6'(merge({26'h0, cfg.dir, cfg.bip, cfg.src},
                                                  WB_DAT_I, WB_SEL_I));
        end
        `AVFR_IDX_FMAX: cfg.fmax <= 16'(merge({16'h0, cfg.fmax}, WB_DAT_I, WB_SEL_I));
        `AVFR_IDX_FILT: cfg.filt_k <= 4'(merge({28'h0, cfg.filt_k}, WB_DAT_I, WB_SEL_I));
        `AVFR_IDX_QLVL: cfg.qlvl <= 16'(merge({16'h0, cfg.qlvl}, WB_DAT_I, WB_SEL_I));
        `AVFR_IDX_NMIN: {cfg.nmin_p, cfg.nmin_v} <=
                          merge({cfg.nmin_p, cfg.nmin_v}, WB_DAT_I, WB_SEL_I);
        `AVFR_IDX_NMAX: {cfg.nmax_p, cfg.nmax_v} <=
                          merge({cfg.nmax_p, cfg.nmax_v}, WB_DAT_I, WB_SEL_I);
        default: ; // status and holes ignore writes
      endcase
    end
  end

  // pipeline sequencer; samples during a pass are dropped
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= avfr_pkg::AVFR_IDLE;
    end else begin
      case (st)
        avfr_pkg::AVFR_IDLE: if (AIN_VALID) st <= avfr_pkg::AVFR_FILT;
        avfr_pkg::AVFR_FILT: st <= avfr_pkg::AVFR_SCALE;
        avfr_pkg::AVFR_SCALE: st <= avfr_pkg::AVFR_OUT;
        avfr_pkg::AVFR_OUT: st <= avfr_pkg::AVFR_IDLE;
        default: st <= avfr_pkg::AVFR_IDLE;
      endcase
    end
  end

  // first-order low-pass; bigger shift smooths more, answers slower
  assign diff = {AIN_MV[SMP_W-1], AIN_MV, {`AVFR_FRAC{1'b0}}} - {acc[23], acc};
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      acc <= 24'h00_0000;
    end else if (st == avfr_pkg::AVFR_IDLE && AIN_VALID) begin
      acc <= acc + 24'(diff >>> cfg.filt_k); // R4
    end
  end
  assign v = acc[23:`AVFR_FRAC];

  // voltage to percent; negative side interpolated between endpoints
  assign den = 17'(cfg.nmax_v - cfg.nmin_v);
  assign num = 34'(17'(v - cfg.nmin_v) * 17'(cfg.nmax_p - cfg.nmin_p));
  always_comb begin
    next_pct = 17'(v);
    if (v >= 0) begin
      next_pct = (v > $signed(`AVFR_FULL_SCALE)) ? 17'($signed(`AVFR_FULL_SCALE)) : 17'(v);
    end else if (!cfg.bip) begin
      next_pct = 17'h0_0000; // R6
    end else if (v <= cfg.nmax_v) begin
      next_pct = 17'(cfg.nmax_p); // R7 R11
    end else if (v >= cfg.nmin_v || den == 17'h0_0000) begin
      next_pct = 17'(cfg.nmin_p); // R11
    end else begin
      next_pct = 17'(cfg.nmin_p + 17'(num / den)); // R7 R11
    end
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pct <= 17'h0_0000;
    end else if (st == avfr_pkg::AVFR_FILT) begin
      pct <= next_pct;
    end
  end

  // quantizer on magnitude: up rounds at 3/4 step, down at 1/4 step
  assign mag = pct[16] ? 17'(-pct) : 17'(pct);
  assign qd = (cfg.qlvl == 16'h0000) ? 17'h0_0001 : {1'b0, cfg.qlvl};
  assign up = 17'(((mag + 17'(cfg.qlvl >> 2)) / qd) * qd); // R1 R2
  assign dn = 17'(((mag + 17'(cfg.qlvl >> 2) - 17'h0_0001) / qd) * qd); // R1 R3
  always_comb begin
    next_lvl = lvl;
    if (cfg.qlvl == 16'h0000) begin
      next_lvl = mag; // R9
    end else if (neg != pct[16]) begin
      next_lvl = up; // sign change restarts from the new side
    end else if (up > lvl) begin
      next_lvl = up; // R2
    end else if (mag + 17'(cfg.qlvl >> 2) == 17'h0_0000) begin
      next_lvl = 17'h0_0000; // R3 falling to zero, dn would wrap here
    end else if (dn < lvl) begin
      next_lvl = dn; // R3
    end
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lvl <= 17'h0_0000;
      neg <= 1'b0;
    end else if (st == avfr_pkg::AVFR_SCALE) begin
      lvl <= next_lvl;
      neg <= pct[16];
    end
  end

  // percent to frequency against full-scale setting
  assign prod = lvl * cfg.fmax;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      FREQ_HZ <= 16'h0000;
      REV <= 1'b0;
      ACTIVE <= 1'b0;
    end else begin
      ACTIVE <= (cfg.src == `AVFR_SRC_VIN); // R5
      if (cfg.src != `AVFR_SRC_VIN) begin
        FREQ_HZ <= 16'h0000; // R5
      end else if (st == avfr_pkg::AVFR_OUT) begin
        FREQ_HZ <= 16'(prod / `AVFR_FULL_SCALE); // R8
        REV <= cfg.dir ^ neg; // R10
      end
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_take;
    st == avfr_pkg::AVFR_IDLE && AIN_VALID;
  endsequence
  sequence s_rest;
    st == avfr_pkg::AVFR_FILT ##1 st == avfr_pkg::AVFR_SCALE ##1 st == avfr_pkg::AVFR_OUT;
  endsequence
  property p_pipe;
    s_take |=> s_rest ##1 st == avfr_pkg::AVFR_IDLE;
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline did not advance");

  property p_step;
    (st == avfr_pkg::AVFR_OUT && cfg.qlvl != 16'h0000) |-> (lvl % qd == 17'h0_0000);
  endproperty
  a_step: assert property (p_step) else $error("level not a whole step"); // R1

  property p_rise;
    (st == avfr_pkg::AVFR_SCALE && cfg.qlvl != 16'h0000 && neg == pct[16]) ##1
      (lvl > $past(lvl)) |-> (mag + 17'(cfg.qlvl >> 2) >= $past(lvl) + qd);
  endproperty
  a_rise: assert property (p_rise) else $error("rose before three quarter step"); // R2

  property p_fall;
    (st == avfr_pkg::AVFR_SCALE && cfg.qlvl != 16'h0000 && neg == pct[16]) ##1
      (lvl < $past(lvl)) |-> (mag + 17'(cfg.qlvl >> 2) <= $past(lvl));
  endproperty
  a_fall: assert property (p_fall) else $error("fell before quarter step"); // R3

  property p_filt;
    (st == avfr_pkg::AVFR_IDLE && AIN_VALID && cfg.filt_k != 4'h0 && diff > 0) |=>
      (acc >= $past(acc) && {acc[23], acc} <= $past({acc[23], acc}) + $past(diff));
  endproperty
  a_filt: assert property (p_filt) else $error("filter overshot"); // R4

  property p_src;
    !ACTIVE |-> FREQ_HZ == 16'h0000;
  endproperty
  a_src: assert property (p_src) else $error("frequency while source not selected"); // R5

  property p_unip;
    (st == avfr_pkg::AVFR_FILT && !cfg.bip) |=> !pct[16];
  endproperty
  a_unip: assert property (p_unip) else $error("negative percent in unipolar"); // R6

  property p_nmax;
    (st == avfr_pkg::AVFR_FILT && cfg.bip && v <= cfg.nmax_v) |=> pct == 17'($past(cfg.nmax_p));
  endproperty
  a_nmax: assert property (p_nmax) else $error("negative endpoint not applied"); // R7

  property p_freq;
    (st == avfr_pkg::AVFR_OUT && cfg.src == `AVFR_SRC_VIN) |=>
      FREQ_HZ == 16'($past(prod) / `AVFR_FULL_SCALE);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency not scaled to full scale"); // R8

  property p_byp;
    (st == avfr_pkg::AVFR_SCALE && cfg.qlvl == 16'h0000) |=> lvl == mag;
  endproperty
  a_byp: assert property (p_byp) else $error("quantizer not bypassed"); // R9

  property p_dir;
    (st == avfr_pkg::AVFR_OUT && cfg.src == `AVFR_SRC_VIN) |=> REV == ($past(cfg.dir) ^ neg);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not flipped by sign"); // R10

  property p_clamp;
    (st == avfr_pkg::AVFR_FILT && cfg.bip && v < 0 && cfg.nmax_p <= cfg.nmin_p) |=>
      (pct >= 17'($past(cfg.nmax_p)) && pct <= 17'($past(cfg.nmin_p)));
  endproperty
  a_clamp: assert property (p_clamp) else $error("percent outside endpoints"); // R11
endmodule // avfr_top
`default_nettype wire

/* verification/analog_voltage_freq_reference_test.sv */
/*
  self-checking bench of the voltage frequency reference block.
  assumes: design files compiled first, sample source model beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module analog_voltage_freq_reference_test;
  logic clk = 1'b0; // 100 MHz
  logic rst_b = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [2:0] adr = 3'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, rev, active, ain_vld;
  logic [15:0] freq;
  logic signed [15:0] ain;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 32'h2965e4e8;
  int qv[15] = '{0, 74, 75, 174, 175, 160, 151, 150, 149, 126, 125, 60, 10000, 9975, 9924};
  // reference model state, mirrors the settings written
  longint acc = 0, lvl = 0, fv = 0, k = 4, q = 4, fmax = 6000;
  longint nv0 = 0, np0 = 0, nv1 = -10000, np1 = -10000;
  bit sgn = 0, bip = 0, dir = 0;
  always #5 clk = ~clk;
  avfr_top i_dut (.CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .AIN_MV(ain), .AIN_VALID(ain_vld), .FREQ_HZ(freq), .REV(rev), .ACTIVE(active));
  avfr_src_model i_src (.CLK(clk), .AIN_MV(ain), .AIN_VALID(ain_vld));
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask
  // one classic cycle; only the bench timeout bounds a lost ack
  task automatic wb(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    chk_flag("ack", 1'b1, ack);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    chk_flag("ack_drop", 1'b0, ack);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0, 4'hf);
    chk_word(nm, e, rdat);
  endtask
  // percent of full scale in 0.01 % units
  function automatic longint pct(input longint f);
    if (f >= 0) return f > 10000 ? 10000 : f;
    if (!bip) return 0;
    if (f <= nv1) return np1;
    if (f >= nv0 || nv0 == nv1) return np0;
    return np0 + (f - nv0) * (np1 - np0) / (nv1 - nv0);
  endfunction
  // send one sample and compare against the model
  task automatic sample(input int v, input int gap, input bit junk);
    longint p, m, up, dn;
    i_src.send(v[15:0], gap, junk);
    acc = acc + ((longint'(v) * 256 - acc) >>> k);
    fv = acc >>> 8;
    p = pct(fv);
    m = p < 0 ? -p : p;
    up = q == 0 ? m : (m + q / 4) / q * q;
    dn = q == 0 ? m : (m + q / 4 - 1) / q * q;
    // rising moves at three quarters, falling at one quarter
    if (q == 0 || (p < 0) != sgn || up > lvl) lvl = up;
    else if (dn < lvl) lvl = dn;
    sgn = p < 0;
    chk_word("freq", lvl * fmax / 10000, {16'h0, freq});
    if (bip || fv >= 0) chk_flag("rev", dir ^ sgn, rev);
  endtask
  initial begin
    // falling edge at time zero so the asynchronous reset really fires
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk_flag("active", 1'b1, active);
    rd_chk(3'h0, 32'h2, "ctrl");
    rd_chk(3'h1, 32'd6000, "fmax");
    rd_chk(3'h2, 32'h4, "filt");
    rd_chk(3'h3, 32'h4, "qlvl");
    rd_chk(3'h4, 32'h0, "nmin");
    rd_chk(3'h5, 32'hd8f0d8f0, "nmax");
    rd_chk(3'h7, 32'h0, "unmapped");
    wb(1'b1, 3'h6, 32'hffffffff, 4'hf);
    rd_chk(3'h6, 32'h00020000, "stat");
    wb(1'b1, 3'h1, 32'h000000aa, 4'h1);
    rd_chk(3'h1, 32'h000017aa, "fmax_lane");
    wb(1'b1, 3'h1, 32'd6000, 4'hf);
    // lighter filter, faster step response
    k = 2;
    q = 0;
    wb(1'b1, 3'h2, 32'h2, 4'hf);
    wb(1'b1, 3'h3, 32'h0, 4'hf);
    repeat (5) sample(8000, 0, 0);
    rd_chk(3'h2, {fv[15:0], 16'h0002}, "filt_out");
    k = 0;
    wb(1'b1, 3'h2, 32'h0, 4'hf);
    sample(10000, 0, 1);
    sample(12000, 3, 0);
    for (int i = 0; i < 8; i++) sample($unsigned($random(seed)) % 12001, i % 3, i[0]);
    // one percent steps of sixty hertz
    q = 100;
    wb(1'b1, 3'h3, 32'd100, 4'hf);
    foreach (qv[i]) sample(qv[i], 0, 0);
    q = 4;
    wb(1'b1, 3'h3, 32'd4, 4'hf);
    for (int i = 0; i < 8; i++) sample(5000 + $random(seed) % 40, 0, 0);
    // bipolar, reverse commanded, default negative endpoints
    bip = 1;
    dir = 1;
    q = 0;
    wb(1'b1, 3'h3, 32'h0, 4'hf);
    wb(1'b1, 3'h0, 32'h32, 4'hf);
    foreach (qv[i]) sample(i[0] ? -qv[i] : qv[i] - 12000, 0, 0);
    nv0 = -1000;
    np0 = -2000;
    nv1 = -9000;
    np1 = -8000;
    wb(1'b1, 3'h4, 32'hf830fc18, 4'hf);
    wb(1'b1, 3'h5, 32'he0c0dcd8, 4'hf);
    for (int i = 0; i < 10; i++) sample(-($unsigned($random(seed)) % 12001), 0, 0);
    sample(-9000, 0, 0);
    sample(-1000, 0, 0);
    dir = 0;
    wb(1'b1, 3'h0, 32'h12, 4'hf);
    sample(-3000, 0, 0);
    sample(4000, 0, 0);
    bip = 0;
    wb(1'b1, 3'h0, 32'h02, 4'hf);
    sample(-4000, 0, 0);
    // another source selected, a voltage sample is ignored
    wb(1'b1, 3'h0, 32'h00, 4'hf);
    i_src.send(16'h1388, 0, 0);
    chk_flag("active_off", 1'b0, active);
    chk_word("freq_off", 32'h0, {16'h0, freq});
    complete_run;
  end
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
endmodule // analog_voltage_freq_reference_test
`default_nettype wire

/* verification/avfr_src_model.sv */
/*
  sample source standing in for the controller voltage output.
  assumes: the block takes a strobed sample at a rising edge while idle.
*/
`timescale 1ns/100ps
`default_nettype none
module avfr_src_model (
  // clock
  input wire logic CLK,
  // sample toward the block
  output logic signed [15:0] AIN_MV,
  output logic AIN_VALID
);
  initial begin
    AIN_MV = 16'h0000;
    AIN_VALID = 1'b0;
  end
  // one sample; gap idles first, junk strobes while the block is busy
  task automatic send(input logic signed [15:0] v, input int gap, input bit junk);
    repeat (gap) @(posedge CLK);
    @(posedge CLK);
    AIN_VALID <= 1'b1;
    AIN_MV <= v;
    @(posedge CLK);
    // line not held after the take, so it shows the inverse
    AIN_VALID <= 1'b0;
    AIN_MV <= ~v;
    @(posedge CLK);
    AIN_VALID <= junk;
    @(posedge CLK);
    AIN_VALID <= 1'b0;
    repeat (2) @(posedge CLK);
    #1;
  endtask
endmodule // avfr_src_model
`default_nettype wire
